// >>> rtl/sdianc_detect.sv
// Ancillary packet detector, flag generator and payload id extractor.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module sdianc_detect
#(
  parameter int FILTER_ENTRIES = sdianc_pkg::FILTER_ENTRIES,
  parameter int PID_TIMEOUT_FRAMES = sdianc_pkg::PID_TIMEOUT_FRAMES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [9:0] vid_luma_in,
  input wire logic [9:0] vid_chroma_in,
  input wire logic input_lock_indicator,
  input wire logic video_processing_select,
  input wire logic smpte_mode,
  output logic [9:0] vid_luma_out,
  output logic [9:0] vid_chroma_out,
  output logic luma_anc_flag,
  output logic chroma_anc_flag,
  output logic error_check_packet_seen,
  output logic [15:0] payload_id_words_low,
  output logic [15:0] payload_id_words_high
);

  localparam int LAG = sdianc_pkg::ANC_LAG;

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------
  function automatic logic filt_match
  (
    input logic [FILTER_ENTRIES-1:0][15:0] ent,
    input logic [7:0] did,
    input logic [7:0] sdid
  );
    logic any;
    logic hit;
    logic [7:0] e_did;
    logic [7:0] e_sdid;
    any = 1'b0;
    hit = 1'b0;
    for (int i = 0; i < FILTER_ENTRIES; i++)
    begin
      e_did = ent[i][sdianc_pkg::DID_MSB:sdianc_pkg::DID_LSB];
      e_sdid = ent[i][sdianc_pkg::SDID_MSB:sdianc_pkg::SDID_LSB];
      // An all-zero entry is unprogrammed and can never match.
      if (ent[i] != 16'h0000)
      begin
        any = 1'b1;
        if ((e_did == 8'h00 || e_did == did) &&
            (e_sdid == 8'h00 || e_sdid == sdid))
          hit = 1'b1;
      end
    end
    return !any || hit;
  endfunction : filt_match

  function automatic logic [8:0] csum_add
  (
    input logic [8:0] acc,
    input logic [9:0] word
  );
    return 9'(acc + word[8:0]);
  endfunction : csum_add

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic [2:0] pin_s1;
  logic [2:0] pin_s2;
  logic pid_clear;
  logic proc_active;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
    end
    else if (clk_en)
    begin
      pin_s1 <= {smpte_mode, video_processing_select,
                 input_lock_indicator};
      pin_s2 <= pin_s1;
    end
  end

  assign pid_clear = !(pin_s2[0] && pin_s2[1]);
  assign proc_active = &pin_s2;

  // ------------------------------------------------------------
  // Register bus
  // ------------------------------------------------------------
  logic ctrl_mux;
  logic [FILTER_ENTRIES-1:0][15:0] entry;
  logic [5:0] reg_idx;
  logic [31:0] rd_value;
  logic rd_hit;
  logic wr_take;

  assign reg_idx = paddr[7:2];
  assign wr_take = psel && penable && pready && pwrite;

  always_comb
  begin
    rd_value = 32'h0000_0000;
    rd_hit = 1'b0;
    case (reg_idx)
      sdianc_pkg::CTRL_IDX:
      begin
        rd_value[sdianc_pkg::CTRL_MUX_BIT] = ctrl_mux;
        rd_hit = 1'b1;
      end
      sdianc_pkg::PAYLOAD_ID_WORDS_LOW_IDX:
      begin
        rd_value[15:0] = payload_id_words_low;
        rd_hit = 1'b1;
      end
      sdianc_pkg::PAYLOAD_ID_WORDS_HIGH_IDX:
      begin
        rd_value[15:0] = payload_id_words_high;
        rd_hit = 1'b1;
      end
      default:
      begin
        rd_hit = 1'b0;
      end
    endcase
    for (int i = 0; i < FILTER_ENTRIES; i++)
    begin
      if (reg_idx == 6'(sdianc_pkg::ANC_FILTER_ENTRY_1_IDX + i))
      begin
        rd_value = {16'h0000, entry[i]};
        rd_hit = 1'b1;
      end
    end
  end

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      if (psel && penable && !pready)
      begin
        pready <= 1'b1;
        pslverr <= !rd_hit;
        prdata <= pwrite ? 32'h0000_0000 : rd_value;
      end
      else
      begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_mux <= sdianc_pkg::CTRL_RESET;
      for (int i = 0; i < FILTER_ENTRIES; i++)
        entry[i] <= sdianc_pkg::ENTRY_RESET;
    end
    else if (clk_en && wr_take)
    begin
      if (reg_idx == sdianc_pkg::CTRL_IDX)
        ctrl_mux <= pwdata[sdianc_pkg::CTRL_MUX_BIT];
      for (int i = 0; i < FILTER_ENTRIES; i++)
      begin
        if (reg_idx == 6'(sdianc_pkg::ANC_FILTER_ENTRY_1_IDX + i))
          entry[i] <= pwdata[15:0];
      end
    end
  end

  // ------------------------------------------------------------
  // Packet parsers, one for each channel
  // ------------------------------------------------------------
  logic [1:0][9:0] vid_in;
  logic [1:0] chan_en;
  sdianc_pkg::sdianc_state_t st [2];
  logic [1:0][7:0] did_q;
  logic [1:0][7:0] dc_left;
  logic [1:0][8:0] csum;
  logic [1:0] match_q;
  logic [1:0] is_pid;
  logic [1:0][1:0] udw_idx;
  logic [1:0][3:0][7:0] pid_words;
  logic [1:0][LAG-1:0][9:0] dly_data;
  logic [1:0][LAG-1:0] dly_mark;
  logic [1:0] new_mark;
  logic [1:0] retro;
  logic [1:0] pid_ok;

  assign vid_in = {vid_chroma_in, vid_luma_in};
  // In 10-bit mode the whole stream is on the luma bus.
  assign chan_en = {proc_active && !ctrl_mux, proc_active};

  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      retro[c] = st[c] == sdianc_pkg::ST_SDID &&
                 filt_match(entry, did_q[c], vid_in[c][7:0]);
      new_mark[c] = retro[c] ||
                    (match_q[c] && (st[c] == sdianc_pkg::ST_DC ||
                     st[c] == sdianc_pkg::ST_UDW ||
                     st[c] == sdianc_pkg::ST_CS));
      pid_ok[c] = st[c] == sdianc_pkg::ST_CS && is_pid[c] &&
                  vid_in[c] == {!csum[c][8], csum[c]};
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int c = 0; c < 2; c++)
      begin
        st[c] <= sdianc_pkg::ST_IDLE;
        pid_words[c] <= 32'h0000_0000;
      end
      did_q <= 16'h0000;
      dc_left <= 16'h0000;
      csum <= 18'h00000;
      match_q <= 2'h0;
      is_pid <= 2'h0;
      udw_idx <= 4'h0;
    end
    else if (clk_en)
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (!chan_en[c])
        begin
          st[c] <= sdianc_pkg::ST_IDLE;
          match_q[c] <= 1'b0;
        end
        else
        begin
          case (st[c])
            sdianc_pkg::ST_IDLE:
            begin
              // Both blanking regions are searched alike.
              if (vid_in[c] == sdianc_pkg::ADF_NEXT &&
                  dly_data[c][0] == sdianc_pkg::ADF_NEXT &&
                  dly_data[c][1] == sdianc_pkg::ADF_FIRST)
                st[c] <= sdianc_pkg::ST_DID;
            end
            sdianc_pkg::ST_DID:
            begin
              did_q[c] <= vid_in[c][7:0];
              csum[c] <= vid_in[c][8:0];
              st[c] <= sdianc_pkg::ST_SDID;
            end
            sdianc_pkg::ST_SDID:
            begin
              csum[c] <= csum_add(csum[c], vid_in[c]);
              match_q[c] <= retro[c];
              is_pid[c] <= did_q[c] == sdianc_pkg::PID_DID &&
                           vid_in[c][7:0] == sdianc_pkg::PID_SDID;
              st[c] <= sdianc_pkg::ST_DC;
            end
            sdianc_pkg::ST_DC:
            begin
              csum[c] <= csum_add(csum[c], vid_in[c]);
              dc_left[c] <= vid_in[c][7:0];
              udw_idx[c] <= 2'h0;
              is_pid[c] <= is_pid[c] &&
                           vid_in[c][7:0] == sdianc_pkg::PID_DC;
              st[c] <= (vid_in[c][7:0] == 8'h00) ?
                       sdianc_pkg::ST_CS : sdianc_pkg::ST_UDW;
            end
            sdianc_pkg::ST_UDW:
            begin
              csum[c] <= csum_add(csum[c], vid_in[c]);
              if (is_pid[c])
                pid_words[c][udw_idx[c]] <= vid_in[c][7:0];
              udw_idx[c] <= 2'(udw_idx[c] + 2'h1);
              dc_left[c] <= 8'(dc_left[c] - 8'h01);
              if (dc_left[c] == 8'h01)
                st[c] <= sdianc_pkg::ST_CS;
            end
            sdianc_pkg::ST_CS:
            begin
              match_q[c] <= 1'b0;
              st[c] <= sdianc_pkg::ST_IDLE;
            end
            default:
            begin
              st[c] <= sdianc_pkg::ST_IDLE;
            end
          endcase
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Delay line and flag outputs
  // ------------------------------------------------------------
  // The match is known at the SDID word, four words after the
  // preamble start, so the line is deep enough to mark backwards.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dly_data <= '0;
      dly_mark <= '0;
    end
    else if (clk_en)
    begin
      for (int c = 0; c < 2; c++)
      begin
        dly_data[c] <= {dly_data[c][LAG-2:0], vid_in[c]};
        dly_mark[c] <= chan_en[c] ?
          {dly_mark[c][LAG-2:0] | {(LAG-1){retro[c]}}, new_mark[c]} :
          '0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vid_luma_out <= 10'h000;
      vid_chroma_out <= 10'h000;
      luma_anc_flag <= 1'b0;
      chroma_anc_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      vid_luma_out <= dly_data[0][LAG-1];
      vid_chroma_out <= dly_data[1][LAG-1];
      luma_anc_flag <= dly_mark[0][LAG-1];
      chroma_anc_flag <= ctrl_mux ? dly_mark[0][LAG-1] :
                         dly_mark[1][LAG-1];
    end
  end

  // Error check packets are seen before any filtering is applied.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      error_check_packet_seen <= 1'b0;
    else if (clk_en)
      error_check_packet_seen <=
        (chan_en[0] && st[0] == sdianc_pkg::ST_DID &&
         vid_in[0][7:0] == sdianc_pkg::EDH_DID) ||
        (chan_en[1] && st[1] == sdianc_pkg::ST_DID &&
         vid_in[1][7:0] == sdianc_pkg::EDH_DID);
  end

  // ------------------------------------------------------------
  // Frame timing and payload identifier registers
  // ------------------------------------------------------------
  logic trs_hit;
  logic [9:0] xyz;
  logic v_prev;
  logic frame_start;
  logic [3:0] frm_cnt;
  logic pid_load;
  logic [15:0] next_pid_low;
  logic [15:0] next_pid_high;

  assign trs_hit = ctrl_mux ?
    (dly_data[0][2] == sdianc_pkg::TRS_FIRST &&
     dly_data[0][1] == sdianc_pkg::TRS_ZERO &&
     dly_data[0][0] == sdianc_pkg::TRS_ZERO) :
    (dly_data[1][0] == sdianc_pkg::TRS_FIRST &&
     dly_data[0][0] == sdianc_pkg::TRS_ZERO &&
     vid_in[1] == sdianc_pkg::TRS_ZERO);
  assign xyz = vid_in[0];
  assign frame_start = proc_active && trs_hit && v_prev &&
                       !xyz[sdianc_pkg::XYZ_V_BIT] &&
                       !xyz[sdianc_pkg::XYZ_F_BIT];
  assign pid_load = pid_ok[0] || pid_ok[1];
  assign next_pid_low = pid_ok[0] ?
    {pid_words[0][1], pid_words[0][0]} :
    {pid_words[1][1], pid_words[1][0]};
  assign next_pid_high = pid_ok[0] ?
    {pid_words[0][3], pid_words[0][2]} :
    {pid_words[1][3], pid_words[1][2]};

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      v_prev <= 1'b0;
    else if (clk_en && trs_hit)
      v_prev <= xyz[sdianc_pkg::XYZ_V_BIT];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      payload_id_words_low <= sdianc_pkg::PID_RESET;
      payload_id_words_high <= sdianc_pkg::PID_RESET;
      frm_cnt <= 4'h0;
    end
    else if (clk_en)
    begin
      if (pid_clear)
      begin
        payload_id_words_low <= sdianc_pkg::PID_RESET;
        payload_id_words_high <= sdianc_pkg::PID_RESET;
        frm_cnt <= 4'h0;
      end
      else if (pid_load)
      begin
        payload_id_words_low <= next_pid_low;
        payload_id_words_high <= next_pid_high;
        frm_cnt <= 4'h0;
      end
      else if (frame_start)
      begin
        // The third frame start since the last good packet closes
        // two whole frames without one.
        if (frm_cnt == 4'(PID_TIMEOUT_FRAMES))
        begin
          payload_id_words_low <= sdianc_pkg::PID_RESET;
          payload_id_words_high <= sdianc_pkg::PID_RESET;
        end
        else
          frm_cnt <= 4'(frm_cnt + 4'h1);
      end
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_sdid_hit;
    clk_en && chan_en[0] && st[0] == sdianc_pkg::ST_SDID &&
    filt_match(entry, did_q[0], vid_in[0][7:0]);
  endsequence

  sequence s_sdid_miss;
    clk_en && chan_en[0] && st[0] == sdianc_pkg::ST_SDID &&
    !filt_match(entry, did_q[0], vid_in[0][7:0]);
  endsequence

  a_mux_flags_equal: assert property (
    $past(ctrl_mux) |-> luma_anc_flag == chroma_anc_flag)
    else $error("flags differ in multiplexed mode");

  a_flag_chan_own: assert property (
    !$past(ctrl_mux) && $past(clk_en) |->
    chroma_anc_flag == $past(dly_mark[1][LAG-1]))
    else $error("chroma flag not from its own channel");

  a_flag_starts_pre: assert property (
    $rose(luma_anc_flag) |-> vid_luma_out == sdianc_pkg::ADF_FIRST)
    else $error("flag rose away from preamble start");

  a_match_marks_pkt: assert property (
    s_sdid_hit |=> dly_mark[0][0] && dly_mark[0][LAG-1])
    else $error("matching packet not marked back to preamble");

  a_filter_rejects: assert property (
    s_sdid_miss |=> !dly_mark[0][0] && !dly_mark[0][LAG-1])
    else $error("filtered packet was marked");

  a_edh_always_seen: assert property (
    clk_en && chan_en[0] && st[0] == sdianc_pkg::ST_DID &&
    vid_in[0][7:0] == sdianc_pkg::EDH_DID |=> error_check_packet_seen)
    else $error("error check packet missed");

  a_pid_load_words: assert property (
    clk_en && !pid_clear && pid_load |=>
    payload_id_words_low == $past(next_pid_low) &&
    payload_id_words_high == $past(next_pid_high))
    else $error("payload words not loaded");

  a_pid_needs_sum: assert property (
    $changed(payload_id_words_high) && payload_id_words_high != 0
    |-> $past(pid_load))
    else $error("payload register changed without good checksum");

  a_pid_clear_lock: assert property (
    clk_en && pid_clear |=>
    payload_id_words_low == 16'h0000 && payload_id_words_high == 16'h0000)
    else $error("payload registers not cleared");

  a_pid_timeout: assert property (
    clk_en && !pid_clear && !pid_load && frame_start &&
    frm_cnt == 4'(PID_TIMEOUT_FRAMES) |=>
    payload_id_words_low == 16'h0000 && payload_id_words_high == 16'h0000)
    else $error("payload registers not cleared after timeout");

  a_idle_inactive: assert property (
    clk_en && !proc_active |=> st[0] == sdianc_pkg::ST_IDLE ##1
    !luma_anc_flag || dly_mark[0][LAG-1])
    else $error("parser ran outside video mode");

endmodule : sdianc_detect

`default_nettype wire

// >>> rtl/sdianc_pkg.sv
// Constants and types shared by the ancillary data detector.
package sdianc_pkg;

  localparam logic [5:0] CTRL_IDX = 6'h00;
  localparam logic [5:0] ANC_FILTER_ENTRY_1_IDX = 6'h05;
  localparam logic [5:0] ANC_FILTER_ENTRY_2_IDX = 6'h06;
  localparam logic [5:0] ANC_FILTER_ENTRY_3_IDX = 6'h07;
  localparam logic [5:0] ANC_FILTER_ENTRY_4_IDX = 6'h08;
  localparam logic [5:0] ANC_FILTER_ENTRY_5_IDX = 6'h09;
  localparam logic [5:0] PAYLOAD_ID_WORDS_LOW_IDX = 6'h0c;
  localparam logic [5:0] PAYLOAD_ID_WORDS_HIGH_IDX = 6'h0d;

  localparam int CTRL_MUX_BIT = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam logic [15:0] ENTRY_RESET = 16'h0000;
  localparam logic [15:0] PID_RESET = 16'h0000;
  localparam int DID_MSB = 15;
  localparam int DID_LSB = 8;
  localparam int SDID_MSB = 7;
  localparam int SDID_LSB = 0;

  localparam logic [9:0] ADF_FIRST = 10'h000;
  localparam logic [9:0] ADF_NEXT = 10'h3ff;
  localparam logic [9:0] TRS_FIRST = 10'h3ff;
  localparam logic [9:0] TRS_ZERO = 10'h000;
  localparam logic [7:0] PID_DID = 8'h41;
  localparam logic [7:0] PID_SDID = 8'h01;
  localparam logic [7:0] PID_DC = 8'h04;
  localparam logic [7:0] EDH_DID = 8'hf4;
  localparam int XYZ_F_BIT = 8;
  localparam int XYZ_V_BIT = 7;

  localparam int FILTER_ENTRIES = 5;
  localparam int ANC_LAG = 5;
  localparam int PID_TIMEOUT_FRAMES = 2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_DID = 3'b001,
    ST_SDID = 3'b010,
    ST_DC = 3'b011,
    ST_UDW = 3'b100,
    ST_CS = 3'b101
  } sdianc_state_t;

endpackage : sdianc_pkg

// >>> verification/sdianc_fifo_model.sv
// Downstream FIFO model that stores video words while an ancillary flag is high.
`timescale 1ns/1ps
`default_nettype none

module sdianc_fifo_model
(
  input wire logic pclk,
  input wire logic clr,
  input wire logic luma_anc_flag,
  input wire logic chroma_anc_flag,
  input wire logic error_check_packet_seen,
  input wire logic [9:0] vid_luma_out,
  input wire logic [9:0] vid_chroma_out,
  output var int luma_words,
  output var int chroma_words,
  output var int check_pkts,
  output var logic [9:0] first_word,
  output var logic [9:0] first_chroma
);

  // --------------------------------------------------------------
  // Write enables
  // --------------------------------------------------------------
  // The flags qualify nothing else: a word is stored on every edge at
  // which a flag is high, so a flag that is one cycle long or short
  // shows up directly as a wrong word count.
  always @(posedge pclk)
  begin
    if (clr)
    begin
      luma_words <= 0;
      chroma_words <= 0;
      check_pkts <= 0;
      first_word <= 10'h155;
      first_chroma <= 10'h155;
    end
    else
    begin
      if (luma_anc_flag && luma_words == 0)
        first_word <= vid_luma_out;
      if (chroma_anc_flag && chroma_words == 0)
        first_chroma <= vid_chroma_out;
      if (luma_anc_flag)
        luma_words <= luma_words + 1;
      if (chroma_anc_flag)
        chroma_words <= chroma_words + 1;
      if (error_check_packet_seen)
        check_pkts <= check_pkts + 1;
    end
  end

endmodule : sdianc_fifo_model

`default_nettype wire

// >>> verification/tb_sdi_anc_detect_payload_id.sv
// Self-checking testbench for the ancillary detector and payload id registers.
`timescale 1ns/1ps
`default_nettype none

module tb_sdi_anc_detect_payload_id;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, clr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0] vid_luma_in, vid_chroma_in, vid_luma_out, vid_chroma_out;
  logic input_lock_indicator, video_processing_select, smpte_mode;
  logic luma_anc_flag, chroma_anc_flag, error_check_packet_seen;
  logic [15:0] payload_id_words_low, payload_id_words_high;
  logic [9:0] first_word, first_chroma;
  int luma_words, chroma_words, check_pkts, bad_count, checked;
  localparam logic [5:0] LOW = sdianc_pkg::PAYLOAD_ID_WORDS_LOW_IDX;
  localparam logic [5:0] HIGH = sdianc_pkg::PAYLOAD_ID_WORDS_HIGH_IDX;
  localparam logic [5:0] E1 = sdianc_pkg::ANC_FILTER_ENTRY_1_IDX;

  sdianc_detect sdianc_detect_i (.pclk(pclk), .presetn(presetn),
    .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .vid_luma_in(vid_luma_in),
    .vid_chroma_in(vid_chroma_in),
    .input_lock_indicator(input_lock_indicator),
    .video_processing_select(video_processing_select),
    .smpte_mode(smpte_mode), .vid_luma_out(vid_luma_out),
    .vid_chroma_out(vid_chroma_out), .luma_anc_flag(luma_anc_flag),
    .chroma_anc_flag(chroma_anc_flag),
    .error_check_packet_seen(error_check_packet_seen),
    .payload_id_words_low(payload_id_words_low),
    .payload_id_words_high(payload_id_words_high));

  sdianc_fifo_model sdianc_fifo_model_i (.pclk(pclk), .clr(clr),
    .luma_anc_flag(luma_anc_flag), .chroma_anc_flag(chroma_anc_flag),
    .error_check_packet_seen(error_check_packet_seen),
    .vid_luma_out(vid_luma_out), .luma_words(luma_words),
    .chroma_words(chroma_words), .check_pkts(check_pkts),
    .first_word(first_word), .vid_chroma_out(vid_chroma_out),
    .first_chroma(first_chroma));

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One APB transfer; the read data and error are taken at the pready edge.
  task automatic rw(input logic wr, input logic [5:0] idx,
                    input logic [31:0] wd, input logic [31:0] exp,
                    input logic err);
    logic [31:0] rd;
    logic se;
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 40)
    begin
      bad_count++;
      final_report();
    end
    check("pslverr", {31'h0, err}, {31'h0, se});
    if (!wr && !err)
      check("prdata", exp, rd);
    @(posedge pclk);
  endtask : rw

  function automatic logic [9:0] mkw(input logic [7:0] b);
    return {~(^b), ^b, b};
  endfunction : mkw

  // Sends one packet and judges how many words each flag enabled.
  task automatic pk(input bit ch, input logic [7:0] did,
                    input logic [7:0] sdid, input int dc,
                    input logic [31:0] u, input bit bad,
                    input int el, input int ec);
    logic [9:0] w[$];
    logic [8:0] s;
    clr <= 1'b1;
    @(posedge pclk);
    clr <= 1'b0;
    w = '{10'h000, 10'h3ff, 10'h3ff, mkw(did), mkw(sdid), mkw(dc[7:0])};
    for (int i = 0; i < dc; i++)
      w.push_back(mkw(u[8*i +: 8]));
    s = 9'h000;
    for (int i = 3; i < w.size(); i++)
      s = s + w[i][8:0];
    s = s + {8'h00, bad};
    w.push_back({~s[8], s});
    foreach (w[i])
    begin
      if (ch)
        vid_chroma_in <= w[i];
      else
        vid_luma_in <= w[i];
      @(posedge pclk);
    end
    vid_luma_in <= 10'h040;
    vid_chroma_in <= 10'h040;
    repeat (12) @(posedge pclk);
    check("luma words", el, luma_words);
    check("chroma words", ec, chroma_words);
    if (el > 0)
      check("first word", 32'h0, {22'h0, first_word});
    if (ch && ec > 0)
      check("first chroma", 32'h0, {22'h0, first_chroma});
  endtask : pk

  // One timing reference in 20-bit form, ending with the given XYZ word.
  task automatic trs(input logic [9:0] xyz);
    vid_luma_in <= 10'h000;
    vid_chroma_in <= 10'h3ff;
    @(posedge pclk);
    vid_luma_in <= xyz;
    vid_chroma_in <= 10'h000;
    @(posedge pclk);
    vid_luma_in <= 10'h040;
    vid_chroma_in <= 10'h040;
    @(posedge pclk);
  endtask : trs

  // A frame boundary: vertical blanking ends at a field one reference.
  task automatic frm();
    trs(10'h2c0);
    trs(10'h240);
  endtask : frm

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_regs();
    logic [5:0] ix;
    logic [15:0] pat;
    for (int i = 0; i < 5; i++)
    begin
      ix = E1 + 6'(i);
      pat = {8'(8'h11 + i), 8'(8'hc0 + i)};
      rw(1'b0, ix, 32'h0, 32'h0, 1'b0);
      rw(1'b1, ix, {16'ha5a5, pat}, 32'h0, 1'b0);
      rw(1'b0, ix, 32'h0, {16'h0, pat}, 1'b0);
      rw(1'b1, ix, 32'h0, 32'h0, 1'b0);
    end
    rw(1'b1, LOW, 32'hffff, 32'h0, 1'b0);
    rw(1'b0, LOW, 32'h0, 32'h0, 1'b0);
    rw(1'b0, HIGH, 32'h0, 32'h0, 1'b0);
    rw(1'b0, 6'h3f, 32'h0, 32'h0, 1'b1);
    $display("test regs done");
  endtask : t_regs

  task automatic t_flags();
    pk(1'b0, 8'h50, 8'h07, 1, 32'h33, 1'b0, 8, 0);
    pk(1'b1, 8'h50, 8'h07, 3, 32'h3, 1'b0, 0, 10);
    rw(1'b1, sdianc_pkg::CTRL_IDX, 32'h1, 32'h0, 1'b0);
    pk(1'b0, 8'h50, 8'h07, 2, 32'h3, 1'b0, 9, 9);
    rw(1'b1, sdianc_pkg::CTRL_IDX, 32'h0, 32'h0, 1'b0);
    smpte_mode <= 1'b0;
    repeat (4) @(posedge pclk);
    pk(1'b0, 8'h50, 8'h07, 1, 32'h33, 1'b0, 0, 0);
    smpte_mode <= 1'b1;
    repeat (4) @(posedge pclk);
    $display("test flags done");
  endtask : t_flags

  task automatic t_filter();
    rw(1'b1, E1, 32'h5000, 32'h0, 1'b0);
    rw(1'b1, E1 + 6'h1, 32'h6122, 32'h0, 1'b0);
    pk(1'b0, 8'h50, 8'h07, 1, 32'h33, 1'b0, 8, 0);
    pk(1'b0, 8'h51, 8'h07, 1, 32'h33, 1'b0, 0, 0);
    pk(1'b0, 8'h61, 8'h22, 1, 32'h33, 1'b0, 8, 0);
    pk(1'b0, 8'h61, 8'h23, 1, 32'h33, 1'b0, 0, 0);
    pk(1'b0, 8'hf4, 8'h00, 1, 32'h33, 1'b0, 0, 0);
    check("check packets", 32'h1, check_pkts);
    rw(1'b1, E1, 32'h0, 32'h0, 1'b0);
    rw(1'b1, E1 + 6'h1, 32'h0, 32'h0, 1'b0);
    $display("test filter done");
  endtask : t_filter

  task automatic t_pid();
    for (int p = 0; p < 2; p++)
    begin
      pk(1'b0, 8'h41, 8'h01, 4, 32'h0ac9_2081, 1'b0, 11, 0);
      rw(1'b0, LOW, 32'h0, 32'h2081, 1'b0);
      rw(1'b0, HIGH, 32'h0, 32'h0ac9, 1'b0);
      pk(1'b0, 8'h41, 8'h01, 4, 32'h1234_5678, 1'b1, 11, 0);
      rw(1'b0, LOW, 32'h0, 32'h2081, 1'b0);
      if (p == 0)
        input_lock_indicator <= 1'b0;
      else
        video_processing_select <= 1'b0;
      repeat (4) @(posedge pclk);
      rw(1'b0, LOW, 32'h0, 32'h0, 1'b0);
      rw(1'b0, HIGH, 32'h0, 32'h0, 1'b0);
      input_lock_indicator <= 1'b1;
      video_processing_select <= 1'b1;
      repeat (4) @(posedge pclk);
    end
    $display("test payload id done");
  endtask : t_pid

  // Loads the words from the chroma channel, then lets frames pass.
  task automatic t_timeout();
    pk(1'b1, 8'h41, 8'h01, 4, 32'h0ac9_2081, 1'b0, 0, 11);
    frm();
    frm();
    rw(1'b0, LOW, 32'h0, 32'h2081, 1'b0);
    rw(1'b0, HIGH, 32'h0, 32'h0ac9, 1'b0);
    frm();
    rw(1'b0, LOW, 32'h0, 32'h0, 1'b0);
    rw(1'b0, HIGH, 32'h0, 32'h0, 1'b0);
    $display("test timeout done");
  endtask : t_timeout

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    clr = 1'b1;
    vid_luma_in = 10'h040;
    vid_chroma_in = 10'h040;
    input_lock_indicator = 1'b1;
    video_processing_select = 1'b1;
    smpte_mode = 1'b1;
    bad_count = 0;
    checked = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    clr <= 1'b0;
    repeat (4) @(posedge pclk);
    t_regs();
    t_flags();
    t_filter();
    t_pid();
    t_timeout();
    final_report();
  end

endmodule : tb_sdi_anc_detect_payload_id

`default_nettype wire
